// File: ocd_serial_port.sv
// Two-wire slave port and command decoder of the oscillator/divider.
// Assumes SCL and SDA are already synchronous to i_clk and that SDA is
// an open-drain wire resolved outside from o_sda and o_sda_oe_n.
`timescale 1ns/1ps
`default_nettype none
`include "ocd_consts.svh"

module ocd_serial_port #(
    parameter logic [3:0] DEV_TYPE_CODE = 4'hA, // Arbitrary value.
    parameter int NV_WRITE_CYCLES = `OCD_NV_WRITE_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Serial bus pins.
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe_n,
    // Device state.
    input wire logic i_power_down,
    // Register contents towards the oscillator datapath.
    output logic [15:0] o_divider_value,
    output logic [15:0] o_output_select,
    output logic [7:0] o_bus_configuration,
    output logic o_nv_busy
);

    ocd_nv_if nv ();

    ocd_nv_store #(
        .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
    ) u_nv_store (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .nv(nv.store)
    );

    ocd_pkg::ocd_state_t state_reg;
    ocd_pkg::ocd_kind_t kind_reg;
    logic scl_reg;
    logic sda_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic byte_done_reg;
    logic ack_reg;
    logic rw_reg;
    logic [7:0] cmd_reg;
    logic idx_reg;
    logic dirty_reg;
    logic load_reg;
    logic [15:0] divider_reg;
    logic [15:0] output_select_reg;
    logic [7:0] bus_config_reg;
    logic commit_reg;
    logic sda_oe_n_reg;

    logic scl_rise;
    logic scl_fall;
    logic start_evt;
    logic stop_evt;
    logic byte_evt;
    logic addr_match;
    logic ack_ok;
    logic ack_next;
    logic data_wr;
    logic cmd_wr;
    logic end_evt;
    logic wc_flag;
    logic [7:0] tx_byte;
    logic drive_low;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end
        else
        begin
            scl_reg <= i_scl;
            sda_reg <= i_sda;
        end
    end

    assign scl_rise = i_scl && !scl_reg;
    assign scl_fall = !i_scl && scl_reg;
    assign start_evt = i_scl && scl_reg && sda_reg && !i_sda;
    assign stop_evt = i_scl && scl_reg && !sda_reg && i_sda;
    assign wc_flag = bus_config_reg[`OCD_BUS_WC_BIT];

    always_comb
    begin
        byte_evt = (state_reg == ocd_pkg::OCD_RX) && byte_done_reg
            && scl_fall && !start_evt && !stop_evt;
        addr_match = (shift_reg[`OCD_TYPE_MSB:`OCD_TYPE_LSB] == DEV_TYPE_CODE)
            && (shift_reg[`OCD_ADDR_SEL_MSB:`OCD_ADDR_SEL_LSB]
            == bus_config_reg[`OCD_BUS_SEL_MSB:`OCD_BUS_SEL_LSB]);
        ack_ok = !nv.busy && !i_power_down;
        if (kind_reg == ocd_pkg::OCD_KIND_ADDR)
            ack_next = addr_match && ack_ok;
        else
            ack_next = ack_ok;
        cmd_wr = byte_evt && ack_ok && (kind_reg == ocd_pkg::OCD_KIND_CMD);
        data_wr = byte_evt && ack_ok && (kind_reg == ocd_pkg::OCD_KIND_DATA);
        end_evt = (start_evt || stop_evt) && dirty_reg;
    end

    // Read data chosen by the last command; two-byte registers go MSB first.
    always_comb
    begin
        unique case (cmd_reg)
            `OCD_CMD_DIVIDER:
                tx_byte = idx_reg ? divider_reg[7:0] : divider_reg[15:8];
            `OCD_CMD_OUTPUT_SELECT:
                tx_byte = idx_reg ? output_select_reg[7:0]
                    : output_select_reg[15:8];
            `OCD_CMD_BUS_CONFIG:
                tx_byte = bus_config_reg;
            default:
                tx_byte = 8'h00;
        endcase
    end

    // Bit-level sequencing of the serial transfer.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg <= ocd_pkg::OCD_IDLE;
            kind_reg <= ocd_pkg::OCD_KIND_ADDR;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            byte_done_reg <= 1'b0;
            ack_reg <= 1'b0;
            rw_reg <= 1'b0;
            idx_reg <= 1'b0;
        end
        else if (start_evt)
        begin
            state_reg <= ocd_pkg::OCD_RX;
            kind_reg <= ocd_pkg::OCD_KIND_ADDR;
            bit_cnt_reg <= 3'h0;
            byte_done_reg <= 1'b0;
        end
        else if (stop_evt)
            state_reg <= ocd_pkg::OCD_IDLE;
        else
        begin
            unique case (state_reg)
                ocd_pkg::OCD_IDLE:
                    byte_done_reg <= 1'b0;
                ocd_pkg::OCD_RX:
                begin
                    if (scl_rise)
                    begin
                        shift_reg <= {shift_reg[6:0], i_sda};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        byte_done_reg <= (bit_cnt_reg == `OCD_LAST_BIT);
                    end
                    else if (byte_evt)
                    begin
                        state_reg <= ocd_pkg::OCD_ACK;
                        ack_reg <= ack_next;
                        byte_done_reg <= 1'b0;
                        if (kind_reg == ocd_pkg::OCD_KIND_ADDR)
                        begin
                            rw_reg <= shift_reg[0];
                            idx_reg <= 1'b0;
                        end
                        else if (kind_reg == ocd_pkg::OCD_KIND_CMD)
                            idx_reg <= 1'b0;
                        else if (ack_ok)
                            idx_reg <= 1'b1;
                    end
                end
                ocd_pkg::OCD_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= 3'h0;
                        if (!ack_reg)
                            state_reg <= ocd_pkg::OCD_IDLE;
                        else if (kind_reg == ocd_pkg::OCD_KIND_ADDR && rw_reg)
                        begin
                            state_reg <= ocd_pkg::OCD_TX;
                            shift_reg <= tx_byte;
                            idx_reg <= 1'b1;
                        end
                        else
                        begin
                            state_reg <= ocd_pkg::OCD_RX;
                            if (kind_reg == ocd_pkg::OCD_KIND_ADDR)
                                kind_reg <= ocd_pkg::OCD_KIND_CMD;
                            else
                                kind_reg <= ocd_pkg::OCD_KIND_DATA;
                        end
                    end
                end
                ocd_pkg::OCD_TX:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_reg == `OCD_LAST_BIT)
                            state_reg <= ocd_pkg::OCD_TX_ACK;
                        else
                            shift_reg <= {shift_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                end
                ocd_pkg::OCD_TX_ACK:
                begin
                    if (scl_rise && i_sda)
                        state_reg <= ocd_pkg::OCD_IDLE;
                    else if (scl_fall)
                    begin
                        state_reg <= ocd_pkg::OCD_TX;
                        shift_reg <= tx_byte;
                        bit_cnt_reg <= 3'h0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cmd_reg <= 8'h00;
        else if (cmd_wr)
            cmd_reg <= shift_reg;
    end

    // Working registers; one cycle after reset they reload the stored image.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            load_reg <= 1'b1;
            divider_reg <= `OCD_DIVIDER_RESET;
            output_select_reg <= `OCD_OUTPUT_SELECT_RESET;
            bus_config_reg <= `OCD_BUS_CONFIG_RESET;
        end
        else if (load_reg)
        begin
            load_reg <= 1'b0;
            divider_reg <= nv.img_divider;
            output_select_reg <= nv.img_output_select;
            bus_config_reg <= nv.img_bus_config & `OCD_BUS_WRITABLE_MASK;
        end
        else if (data_wr)
        begin
            unique case (cmd_reg)
                `OCD_CMD_DIVIDER:
                    if (idx_reg)
                        divider_reg[7:0] <= shift_reg;
                    else
                        divider_reg[15:8] <= shift_reg;
                `OCD_CMD_OUTPUT_SELECT:
                    if (idx_reg)
                        output_select_reg[7:0] <= shift_reg;
                    else
                        output_select_reg[15:8] <= shift_reg;
                `OCD_CMD_BUS_CONFIG:
                    bus_config_reg <= shift_reg
                        & `OCD_BUS_WRITABLE_MASK;
                default:
                    divider_reg <= divider_reg;
            endcase
        end
    end

    // Tracks uncommitted writes so that a memory write follows the transfer while the WC bit is clear.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            dirty_reg <= 1'b0;
        else if (data_wr && cmd_reg != `OCD_CMD_BUS_CONFIG
            && cmd_reg != `OCD_CMD_NV_COMMIT)
            dirty_reg <= 1'b1;
        else if (end_evt || commit_reg)
            dirty_reg <= 1'b0;
    end

    // The bus-configuration commit waits one cycle so the new value is stored.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            commit_reg <= 1'b0;
        else
            commit_reg <= (data_wr && cmd_reg == `OCD_CMD_BUS_CONFIG)
                || (cmd_wr && shift_reg == `OCD_CMD_NV_COMMIT
                && wc_flag)
                || (end_evt && !wc_flag);
    end

    assign nv.commit = commit_reg;
    assign nv.wr_divider = divider_reg;
    assign nv.wr_output_select = output_select_reg;
    assign nv.wr_bus_config = bus_config_reg;

    always_comb
    begin
        drive_low = ((state_reg == ocd_pkg::OCD_ACK) && ack_reg)
            || ((state_reg == ocd_pkg::OCD_TX) && !shift_reg[7]);
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            sda_oe_n_reg <= 1'b1;
        else
            sda_oe_n_reg <= !drive_low || start_evt || stop_evt;
    end

    assign o_sda = 1'b0;
    assign o_sda_oe_n = sda_oe_n_reg;
    assign o_divider_value = divider_reg;
    assign o_output_select = output_select_reg;
    assign o_bus_configuration = bus_config_reg;
    assign o_nv_busy = nv.busy;

endmodule

`default_nettype wire

// File: ocd_consts.svh
// Constants of the oscillator/divider serial command port.
// Assumes a 100 MHz system clock and byte-wide serial transfers.
`ifndef OCD_CONSTS_SVH
`define OCD_CONSTS_SVH

`define OCD_CLK_PERIOD_NS 10
`define OCD_NV_WRITE_TIME_NS 10000
`define OCD_NV_WRITE_CYCLES (`OCD_NV_WRITE_TIME_NS / `OCD_CLK_PERIOD_NS)

`define OCD_CMD_DIVIDER 8'h01
`define OCD_CMD_OUTPUT_SELECT 8'h02
`define OCD_CMD_BUS_CONFIG 8'h0D
`define OCD_CMD_NV_COMMIT 8'h3F

`define OCD_BUS_SEL_LSB 0
`define OCD_BUS_SEL_MSB 2
`define OCD_BUS_WC_BIT 3
`define OCD_BUS_WRITABLE_MASK 8'h0F

`define OCD_DIVIDER_RESET 16'h0000
`define OCD_OUTPUT_SELECT_RESET 16'h0000
`define OCD_BUS_CONFIG_RESET 8'h00

`define OCD_TYPE_MSB 7
`define OCD_TYPE_LSB 4
`define OCD_ADDR_SEL_MSB 3
`define OCD_ADDR_SEL_LSB 1
`define OCD_LAST_BIT 3'h7

`endif

// File: ocd_pkg.sv
// Types of the oscillator/divider serial command port.
// Assumes the constants header is compiled alongside.
package ocd_pkg;

    typedef enum logic [2:0] {
        OCD_IDLE,
        OCD_RX,
        OCD_ACK,
        OCD_TX,
        OCD_TX_ACK
    } ocd_state_t;

    typedef enum logic [1:0] {
        OCD_KIND_ADDR,
        OCD_KIND_CMD,
        OCD_KIND_DATA
    } ocd_kind_t;

endpackage

// File: ocd_nv_if.sv
// Link between the command decoder and the nonvolatile store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface ocd_nv_if;
    logic commit;
    logic [15:0] wr_divider;
    logic [15:0] wr_output_select;
    logic [7:0] wr_bus_config;
    logic busy;
    logic [15:0] img_divider;
    logic [15:0] img_output_select;
    logic [7:0] img_bus_config;

    modport ctrl (
        output commit, wr_divider, wr_output_select, wr_bus_config,
        input busy, img_divider, img_output_select, img_bus_config
    );
    modport store (
        input commit, wr_divider, wr_output_select, wr_bus_config,
        output busy, img_divider, img_output_select, img_bus_config
    );
endinterface

`default_nettype wire

// File: ocd_nv_store.sv
// Nonvolatile image of the three registers with a write-busy timer.
// Assumes commit is a one-cycle pulse raised only while busy is low.
`timescale 1ns/1ps
`default_nettype none
`include "ocd_consts.svh"

module ocd_nv_store #(
    parameter int NV_WRITE_CYCLES = `OCD_NV_WRITE_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Decoder side.
    ocd_nv_if.store nv
);

    logic [15:0] divider_reg;
    logic [15:0] output_select_reg;
    logic [7:0] bus_config_reg;
    logic [31:0] busy_cnt_reg;

    // The image holds the factory defaults until the first commit.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            divider_reg <= `OCD_DIVIDER_RESET;
            output_select_reg <= `OCD_OUTPUT_SELECT_RESET;
            bus_config_reg <= `OCD_BUS_CONFIG_RESET;
        end
        else if (nv.commit && busy_cnt_reg == 32'h0)
        begin
            divider_reg <= nv.wr_divider;
            output_select_reg <= nv.wr_output_select;
            bus_config_reg <= nv.wr_bus_config;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            busy_cnt_reg <= 32'h0;
        else if (nv.commit && busy_cnt_reg == 32'h0)
            busy_cnt_reg <= 32'(NV_WRITE_CYCLES);
        else if (busy_cnt_reg != 32'h0)
            busy_cnt_reg <= busy_cnt_reg - 32'h1;
    end

    assign nv.busy = (busy_cnt_reg != 32'h0);
    assign nv.img_divider = divider_reg;
    assign nv.img_output_select = output_select_reg;
    assign nv.img_bus_config = bus_config_reg;

endmodule

`default_nettype wire

// File: ocd_serial_port_assertions.sv
// Concurrent checks on the serial command port's pins and registers.
// Assumes it is bound into the port module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ocd_sp_assertions #(
    parameter int NV_WRITE_CYCLES = 1000
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Serial pins and device state.
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda,
    input wire logic o_sda_oe_n,
    input wire logic i_power_down,
    // Register contents.
    input wire logic [15:0] o_divider_value,
    input wire logic [15:0] o_output_select,
    input wire logic [7:0] o_bus_configuration,
    input wire logic o_nv_busy
);
    int busy_cnt;
    always_ff @(posedge i_clk or negedge i_rst_n)
        if (!i_rst_n)
            busy_cnt <= 0;
        else
            busy_cnt <= o_nv_busy ? busy_cnt + 1 : 0;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence ack_held;
        !o_sda_oe_n [*3];
    endsequence
    reserved_zero_a: assert property (o_bus_configuration[7:4] == 4'h0)
        else $error("reserved bus bits set");
    busy_nack_a: assert property (busy_cnt > 15 |-> o_sda_oe_n)
        else $error("driven while store busy");
    busy_length_a: assert property ($fell(o_nv_busy) |-> busy_cnt == NV_WRITE_CYCLES)
        else $error("store busy length wrong");
    divider_update_a: assert property ($changed(o_divider_value) |-> !i_scl && !i_power_down)
        else $error("divider changed out of place");
    mux_update_a: assert property ($changed(o_output_select) |-> !i_scl && !i_power_down)
        else $error("output select changed out of place");
    bus_update_a: assert property ($changed(o_bus_configuration) |-> !i_scl && !i_power_down)
        else $error("bus config changed out of place");
    ack_stand_a: assert property ($fell(o_sda_oe_n) |=> ack_held)
        else $error("data drive too short");
    drive_phase_a: assert property ($changed(o_sda_oe_n) |-> !i_scl)
        else $error("data drive changed with clock high");
    pd_release_a: assert property (i_power_down && $past(i_power_down) |-> o_sda_oe_n)
        else $error("driven in power down");
endmodule
bind ocd_serial_port ocd_sp_assertions #(
    .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) u_ocd_sp_assertions (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .i_power_down(i_power_down),
    .o_divider_value(o_divider_value), .o_output_select(o_output_select),
    .o_bus_configuration(o_bus_configuration), .o_nv_busy(o_nv_busy));
`default_nettype wire

// File: ocd_i2c_master.sv
// Behavioural two-wire bus master for the serial command port.
// Assumes the bench resolves SDA with a pull-up from all drivers.
`timescale 1ns/1ps
`default_nettype none
module ocd_i2c_master (
    // Clock and resolved data line.
    input wire logic i_clk,
    input wire logic i_sda,
    // Master drivers, high means released.
    output logic o_scl,
    output logic o_sda
);
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Start is cond(1,0), repeated start too; stop is cond(0,1).
    task automatic cond(input logic a, input logic b);
        tick(2);
        o_sda <= a;
        tick(4);
        o_scl <= 1'b1;
        tick(5);
        o_sda <= b;
        tick(5);
        o_scl <= b;
    endtask
    // Nine bits MSB first; the last one is the acknowledge slot.
    task automatic xfer(input logic [8:0] w, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            tick(2);
            o_sda <= w[i];
            tick(4);
            o_scl <= 1'b1;
            tick(5);
            r[i] = i_sda;
            o_scl <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// File: ocd_serial_port_test.sv
// Self-checking bench for the serial command port.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "ocd_consts.svh"
module ocd_serial_port_test;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_power_down = 1'b0;
    logic scl_m, sda_m, o_sda, o_sda_oe_n, o_nv_busy, ack;
    logic [15:0] o_divider_value, o_output_select, v;
    logic [7:0] o_bus_configuration;
    int err_count = 0;
    int comparisons = 0;
    wire logic sda_w = sda_m & (o_sda_oe_n | o_sda);
    always #5 i_clk = ~i_clk;
    ocd_serial_port #(.NV_WRITE_CYCLES(300)) u_ocd_serial_port (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(scl_m), .i_sda(sda_w),
        .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
        .i_power_down(i_power_down), .o_divider_value(o_divider_value),
        .o_output_select(o_output_select),
        .o_bus_configuration(o_bus_configuration), .o_nv_busy(o_nv_busy));
    ocd_i2c_master u_ocd_i2c_master (.i_clk(i_clk), .i_sda(sda_w),
        .o_scl(scl_m), .o_sda(sda_m));
    task automatic summarize();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, g);
        comparisons++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic xb(input logic [7:0] b, input logic m);
        logic [8:0] r;
        u_ocd_i2c_master.xfer({b, m}, r);
        v = {v[7:0], r[8:1]};
        ack = !r[0];
    endtask
    // Writes n bytes of d, MSB first; ack keeps the control answer.
    task automatic wr(input logic [7:0] c, cmd, input logic [15:0] d,
        input int n);
        logic a;
        u_ocd_i2c_master.cond(1'b1, 1'b0);
        xb(c, 1'b1);
        a = ack;
        if (a)
        begin
            xb(cmd, 1'b1);
            for (int i = 0; i < n; i++)
                xb(d[15-8*i -: 8], 1'b1);
        end
        u_ocd_i2c_master.cond(1'b0, 1'b1);
        ack = a;
    endtask
    task automatic rd(input logic [7:0] c, cmd, input int n);
        u_ocd_i2c_master.cond(1'b1, 1'b0);
        xb(c, 1'b1);
        xb(cmd, 1'b1);
        u_ocd_i2c_master.cond(1'b1, 1'b0);
        xb(c | 8'h01, 1'b1);
        for (int i = 1; i <= n; i++)
            xb(8'hFF, i == n);
        u_ocd_i2c_master.cond(1'b0, 1'b1);
    endtask
    task automatic nv_wait();
        for (int i = 0; i < 400 && o_nv_busy !== 1'b0; i++)
            @(posedge i_clk);
    endtask
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk("divider", 16'h0000, o_divider_value);
        chk("mux", 16'h0000, o_output_select);
        chk("bus", 16'h0000, o_bus_configuration);
        chk("busy", 16'h0000, o_nv_busy);
        chk("sda", 16'h0000, o_sda);
        chk("sda oe", 16'h0001, o_sda_oe_n);
        wr(8'hA0, `OCD_CMD_DIVIDER, 16'h1234, 2);
        chk("ack", 16'h0001, ack);
        chk("divider", 16'h1234, o_divider_value);
        chk("busy", 16'h0001, o_nv_busy);
        wr(8'hA0, `OCD_CMD_DIVIDER, 16'h0000, 1);
        chk("ack busy", 16'h0000, ack);
        nv_wait();
        rd(8'hA0, `OCD_CMD_DIVIDER, 2);
        chk("read divider", 16'h1234, v);
        wr(8'hA0, `OCD_CMD_OUTPUT_SELECT, 16'h5678, 2);
        nv_wait();
        wr(8'hA0, `OCD_CMD_OUTPUT_SELECT, 16'hAB00, 1);
        chk("mux", 16'hAB78, o_output_select);
        nv_wait();
        rd(8'hA0, `OCD_CMD_OUTPUT_SELECT, 2);
        chk("read mux", 16'hAB78, v);
        wr(8'hA2, `OCD_CMD_DIVIDER, 16'h0000, 2);
        chk("ack sel", 16'h0000, ack);
        wr(8'hB0, `OCD_CMD_DIVIDER, 16'h0000, 2);
        chk("ack type", 16'h0000, ack);
        chk("divider", 16'h1234, o_divider_value);
        wr(8'hA0, `OCD_CMD_BUS_CONFIG, 16'hFB00, 1);
        chk("bus", 16'h000B, o_bus_configuration);
        nv_wait();
        wr(8'hA0, `OCD_CMD_DIVIDER, 16'h0000, 2);
        chk("ack old sel", 16'h0000, ack);
        wr(8'hA6, `OCD_CMD_DIVIDER, 16'h00FF, 2);
        chk("divider", 16'h00FF, o_divider_value);
        chk("no commit", 16'h0000, o_nv_busy);
        wr(8'hA6, `OCD_CMD_NV_COMMIT, 16'h0000, 0);
        chk("commit", 16'h0001, o_nv_busy);
        nv_wait();
        wr(8'hA6, `OCD_CMD_BUS_CONFIG, 16'h0B00, 1);
        chk("bus commit", 16'h0001, o_nv_busy);
        nv_wait();
        rd(8'hA6, `OCD_CMD_BUS_CONFIG, 1);
        chk("read bus", 16'h000B, v[7:0]);
        i_power_down <= 1'b1;
        wr(8'hA6, `OCD_CMD_DIVIDER, 16'h5555, 2);
        chk("ack pd", 16'h0000, ack);
        chk("divider pd", 16'h00FF, o_divider_value);
        i_power_down <= 1'b0;
        summarize();
    end
    initial
    begin
        repeat (60000) @(posedge i_clk);
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
